// file: hdl/phrd_top.sv
// protected handler range decoder with apb configuration registers
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "phrd_regs.svh"
module phrd_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input phrd_pkg::phrd_req_s req,
	input wire logic system_management_mode,
	output phrd_pkg::phrd_route_s route,
	output logic ack_cycle_valid,
	output phrd_pkg::phrd_cyc_e ack_cycle_kind
);

	phrd_pkg::phrd_cfg_s cfg;
	logic [31:0] handler_base_reg;
	logic protect_config_lock;
	logic entry_cycle_disable;
	logic exit_cycle_disable;
	logic [7:0] entry_count;
	logic [7:0] exit_count;
	phrd_pkg::phrd_dest_e last_dest;
	logic [2:0] last_mtype;

	// apb decode
	wire logic acc_phase;
	wire logic xfer_done;
	wire logic wr_en;
	wire logic sel_base_lo;
	wire logic sel_base_hi;
	wire logic sel_mask_lo;
	wire logic sel_mask_hi;
	wire logic sel_hwcfg;
	wire logic sel_handler;
	wire logic sel_status;
	wire logic sel_cyccnt;
	wire logic addr_ok;
	wire logic wr_open;
	wire logic [31:0] rd_word;

	// next values of the configuration
	wire phrd_pkg::phrd_cfg_s next_cfg;
	wire logic [31:0] next_handler_base;
	wire logic next_lock;
	wire logic next_entry_dis;
	wire logic next_exit_dis;

	// range match results
	wire phrd_pkg::phrd_dest_e match_dest;
	wire logic [2:0] match_mtype;
	wire logic match_var_hit;
	wire logic match_fixed_hit;

	// special cycle generator outputs
	wire logic cyc_valid;
	wire phrd_pkg::phrd_cyc_e cyc_kind;

	// one wait state: pready rises on the second access cycle
	assign acc_phase = psel && penable;
	assign xfer_done = acc_phase && pready;
	assign wr_en = xfer_done && pwrite;

	assign sel_base_lo = (paddr == `PHRD_OFS_BASE_LO);
	assign sel_base_hi = (paddr == `PHRD_OFS_BASE_HI);
	assign sel_mask_lo = (paddr == `PHRD_OFS_MASK_LO);
	assign sel_mask_hi = (paddr == `PHRD_OFS_MASK_HI);
	assign sel_hwcfg = (paddr == `PHRD_OFS_HWCFG);
	assign sel_handler = (paddr == `PHRD_OFS_HANDLER);
	assign sel_status = (paddr == `PHRD_OFS_STATUS);
	assign sel_cyccnt = (paddr == `PHRD_OFS_CYCCNT);
	assign addr_ok = sel_base_lo || sel_base_hi || sel_mask_lo ||
		sel_mask_hi || sel_hwcfg || sel_handler || sel_status ||
		sel_cyccnt;

	// locked fields keep their value; the close bits stay writable
	assign wr_open = !protect_config_lock;

	assign next_cfg.base[31:17] = (wr_en && sel_base_lo && wr_open)
		? pwdata[`PHRD_FLD_ADDR_LO] : cfg.base[31:17];
	assign next_cfg.base[39:32] = (wr_en && sel_base_hi && wr_open)
		? pwdata[`PHRD_FLD_ADDR_HI] : cfg.base[39:32];
	assign next_cfg.mask[31:17] = (wr_en && sel_mask_lo && wr_open)
		? pwdata[`PHRD_FLD_ADDR_LO] : cfg.mask[31:17];
	assign next_cfg.mask[39:32] = (wr_en && sel_mask_hi && wr_open)
		? pwdata[`PHRD_FLD_ADDR_HI] : cfg.mask[39:32];
	assign next_cfg.var_range_dram_type =
		(wr_en && sel_mask_lo && wr_open)
		? pwdata[`PHRD_FLD_VAR_DRAM] : cfg.var_range_dram_type;
	assign next_cfg.fixed_dram_type = (wr_en && sel_mask_lo && wr_open)
		? pwdata[`PHRD_FLD_FIXED_DRAM] : cfg.fixed_dram_type;
	assign next_cfg.var_range_io_type_sel =
		(wr_en && sel_mask_lo && wr_open)
		? pwdata[`PHRD_BIT_VAR_IO] : cfg.var_range_io_type_sel;
	assign next_cfg.fixed_range_io_type_sel =
		(wr_en && sel_mask_lo && wr_open)
		? pwdata[`PHRD_BIT_FIXED_IO] : cfg.fixed_range_io_type_sel;
	assign next_cfg.var_valid = (wr_en && sel_mask_lo && wr_open)
		? pwdata[`PHRD_BIT_VAR_VALID] : cfg.var_valid;
	assign next_cfg.fixed_range_valid = (wr_en && sel_mask_lo && wr_open)
		? pwdata[`PHRD_BIT_FIXED_VALID]
		: cfg.fixed_range_valid;
	assign next_cfg.var_close = (wr_en && sel_mask_lo)
		? pwdata[`PHRD_BIT_VAR_CLOSE] : cfg.var_close;
	assign next_cfg.fixed_close = (wr_en && sel_mask_lo)
		? pwdata[`PHRD_BIT_FIXED_CLOSE]
		: cfg.fixed_close;

	assign next_handler_base = (wr_en && sel_handler && wr_open)
		? pwdata : handler_base_reg;

	// lock is set-only; a write of 0 never clears it
	assign next_lock = protect_config_lock ||
		(wr_en && sel_hwcfg && pwdata[`PHRD_BIT_LOCK]);
	assign next_entry_dis = (wr_en && sel_hwcfg && wr_open)
		? pwdata[`PHRD_BIT_ENTRY_DIS] : entry_cycle_disable;
	assign next_exit_dis = (wr_en && sel_hwcfg && wr_open)
		? pwdata[`PHRD_BIT_EXIT_DIS] : exit_cycle_disable;

	// read mux; unmapped offsets read zero
	assign rd_word =
		sel_base_lo ? {cfg.base[31:17], 17'h00000} :
		sel_base_hi ? {24'h000000, cfg.base[39:32]} :
		sel_mask_lo ? {cfg.mask[31:17], 2'h0,
			cfg.var_range_dram_type, 1'b0, cfg.fixed_dram_type,
			2'h0, cfg.var_range_io_type_sel,
			cfg.fixed_range_io_type_sel, cfg.var_close,
			cfg.fixed_close, cfg.var_valid,
			cfg.fixed_range_valid} :
		sel_mask_hi ? {24'h000000, cfg.mask[39:32]} :
		sel_hwcfg ? {29'h00000000, exit_cycle_disable,
			entry_cycle_disable, protect_config_lock} :
		sel_handler ? handler_base_reg :
		sel_status ? {21'h000000, last_mtype, 1'b0, last_dest,
			2'h0, protect_config_lock, system_management_mode} :
		sel_cyccnt ? {16'h0000, exit_count, entry_count} :
		`PHRD_ZERO32;

	phrd_range_match u_match (
		.cfg(cfg),
		.addr(req.addr),
		.kind(req.kind),
		.in_mode(system_management_mode),
		.dest(match_dest),
		.mtype(match_mtype),
		.var_hit(match_var_hit),
		.fixed_hit(match_fixed_hit)
	);

	phrd_spec_cycle u_cycle (
		.pclk(pclk),
		.presetn(presetn),
		.in_mode(system_management_mode),
		.entry_cycle_disable(entry_cycle_disable),
		.exit_cycle_disable(exit_cycle_disable),
		.cyc_valid(cyc_valid),
		.cyc_kind(cyc_kind)
	);

	// apb answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `PHRD_ZERO32;
		end else begin
			pready <= acc_phase && !pready;
			pslverr <= acc_phase && !pready && !addr_ok;
			prdata <= (acc_phase && !pready && !pwrite) ? rd_word
				: `PHRD_ZERO32;
		end
	end

	// configuration; only the asynchronous reset returns the lock to 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= '0;
			handler_base_reg <= `PHRD_ZERO32;
			protect_config_lock <= 1'b0;
			entry_cycle_disable <= 1'b0;
			exit_cycle_disable <= 1'b0;
		end else begin
			cfg <= next_cfg;
			handler_base_reg <= next_handler_base;
			protect_config_lock <= next_lock;
			entry_cycle_disable <= next_entry_dis;
			exit_cycle_disable <= next_exit_dis;
		end
	end

	// routed access, one cycle after the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route.valid <= 1'b0;
			route.dest <= phrd_pkg::PHRD_DEST_NORMAL;
			route.mtype <= `PHRD_MTYPE_NONE;
			route.var_hit <= 1'b0;
			route.fixed_hit <= 1'b0;
			route.addr <= 40'h00_0000_0000;
		end else begin
			route.valid <= req.valid;
			route.dest <= match_dest;
			route.mtype <= match_mtype;
			route.var_hit <= match_var_hit;
			route.fixed_hit <= match_fixed_hit;
			route.addr <= req.addr;
		end
	end

	// last decision kept for software to inspect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_dest <= phrd_pkg::PHRD_DEST_NORMAL;
			last_mtype <= `PHRD_MTYPE_NONE;
		end else if (req.valid) begin
			last_dest <= match_dest;
			last_mtype <= match_mtype;
		end
	end

	// acknowledge cycles, counted so software can see suppression work
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_cycle_valid <= 1'b0;
			ack_cycle_kind <= phrd_pkg::PHRD_CYC_ENTRY;
			entry_count <= 8'h00;
			exit_count <= 8'h00;
		end else begin
			ack_cycle_valid <= cyc_valid;
			ack_cycle_kind <= cyc_kind;
			if (cyc_valid && cyc_kind == phrd_pkg::PHRD_CYC_ENTRY) begin
				entry_count <= entry_count + 8'h01;
			end
			if (cyc_valid && cyc_kind == phrd_pkg::PHRD_CYC_EXIT) begin
				exit_count <= exit_count + 8'h01;
			end
		end
	end

endmodule : phrd_top

// file: shared/phrd_regs.svh
// register offsets, field positions and fixed constants of the range decoder
// Overview of operation
// - variable range applies only while its valid bit is set; fixed range only while its own valid bit is set
// - variable base takes programmed bits 39:17, low 17 bits zero
// - variable range extent comes from the mask field at address bits 39:17
// - address in variable range when addr AND mask equals base AND mask
// - outside the mode, variable hits go to I/O, UC or WC per type bit
// - inside the mode, variable hits go to DRAM with the DRAM type field
// - fixed close bit sends data accesses of the fixed range to I/O
// - variable close bit sends data accesses of the variable range to I/O
// - instruction fetches and table walks still reach DRAM while closed
// - lock bit 0 of hardware config register freezes protected configuration
// - when locked, all protected fields except the two close bits ignore writes
// - only reset clears the lock; software writes cannot
// - acknowledge special cycle is issued on mode entry and on mode exit
// - entry disable suppresses entry cycle, exit disable suppresses exit cycle
// - fixed range is A0000-BFFFF; I/O UC/WC outside mode, DRAM inside
// - mask register bits: 3 var close, 2 fixed close, 1 var valid, 0 fixed valid
`ifndef PHRD_REGS_SVH
`define PHRD_REGS_SVH

`define PHRD_OFS_BASE_LO 8'h00
`define PHRD_OFS_BASE_HI 8'h04
`define PHRD_OFS_MASK_LO 8'h08
`define PHRD_OFS_MASK_HI 8'h0c
`define PHRD_OFS_HWCFG 8'h10
`define PHRD_OFS_HANDLER 8'h14
`define PHRD_OFS_STATUS 8'h18
`define PHRD_OFS_CYCCNT 8'h1c

`define PHRD_BIT_FIXED_VALID 0
`define PHRD_BIT_VAR_VALID 1
`define PHRD_BIT_FIXED_CLOSE 2
`define PHRD_BIT_VAR_CLOSE 3
`define PHRD_BIT_FIXED_IO 4
`define PHRD_BIT_VAR_IO 5
`define PHRD_FLD_FIXED_DRAM 10:8
`define PHRD_FLD_VAR_DRAM 14:12
`define PHRD_FLD_ADDR_LO 31:17
`define PHRD_FLD_ADDR_HI 7:0

`define PHRD_BIT_LOCK 0
`define PHRD_BIT_ENTRY_DIS 1
`define PHRD_BIT_EXIT_DIS 2

`define PHRD_FIXED_PAGE 23'h000005
`define PHRD_MTYPE_UC 3'h0
`define PHRD_MTYPE_WC 3'h1
`define PHRD_MTYPE_NONE 3'h0
`define PHRD_ZERO32 32'h0000_0000

`endif

// file: shared/phrd_pkg.sv
// types shared by the protected range decoder modules
package phrd_pkg;

	typedef enum logic [2:0] {
		PHRD_DEST_NORMAL = 3'b001,
		PHRD_DEST_DRAM = 3'b010,
		PHRD_DEST_IO = 3'b100
	} phrd_dest_e;

	typedef enum logic [2:0] {
		PHRD_ACC_DATA = 3'b001,
		PHRD_ACC_INSTR = 3'b010,
		PHRD_ACC_WALK = 3'b100
	} phrd_acc_e;

	typedef enum logic [1:0] {
		PHRD_CYC_ENTRY = 2'b01,
		PHRD_CYC_EXIT = 2'b10
	} phrd_cyc_e;

	typedef struct packed {
		logic [39:17] base;
		logic [39:17] mask;
		logic [2:0] var_range_dram_type;
		logic [2:0] fixed_dram_type;
		logic var_range_io_type_sel;
		logic fixed_range_io_type_sel;
		logic var_close;
		logic fixed_close;
		logic var_valid;
		logic fixed_range_valid;
	} phrd_cfg_s;

	typedef struct packed {
		logic valid;
		phrd_acc_e kind;
		logic [39:0] addr;
	} phrd_req_s;

	typedef struct packed {
		logic valid;
		phrd_dest_e dest;
		logic [2:0] mtype;
		logic var_hit;
		logic fixed_hit;
		logic [39:0] addr;
	} phrd_route_s;

endpackage : phrd_pkg

// file: hdl/phrd_range_match.sv
// combinational range test and routing of one core address
`timescale 1ns/10ps
`include "phrd_regs.svh"
module phrd_range_match (
	input phrd_pkg::phrd_cfg_s cfg,
	input wire logic [39:0] addr,
	input phrd_pkg::phrd_acc_e kind,
	input wire logic in_mode,
	output phrd_pkg::phrd_dest_e dest,
	output logic [2:0] mtype,
	output logic var_hit,
	output logic fixed_hit
);

	function automatic logic [2:0] io_type(input logic wc_sel);
		io_type = wc_sel ? `PHRD_MTYPE_WC : `PHRD_MTYPE_UC;
	endfunction : io_type

	wire logic is_data;
	wire logic var_to_io;
	wire logic fixed_to_io;
	wire logic [2:0] var_mtype;
	wire logic [2:0] fixed_mtype;

	// base is only bits 39:17, so the range starts on a 128 KB boundary
	assign var_hit = cfg.var_valid &&
		((addr[39:17] & cfg.mask) == (cfg.base & cfg.mask));
	assign fixed_hit = cfg.fixed_range_valid &&
		(addr[39:17] == `PHRD_FIXED_PAGE);

	// fetches and walks ignore close so the handler keeps running from dram
	assign is_data = (kind == phrd_pkg::PHRD_ACC_DATA);
	assign var_to_io = !in_mode || (cfg.var_close && is_data);
	assign fixed_to_io = !in_mode || (cfg.fixed_close && is_data);
	assign var_mtype = var_to_io ? io_type(cfg.var_range_io_type_sel)
		: cfg.var_range_dram_type;
	assign fixed_mtype = fixed_to_io ? io_type(cfg.fixed_range_io_type_sel)
		: cfg.fixed_dram_type;

	// variable range wins an overlap; software keeps overlaps consistent
	assign dest = var_hit ? (var_to_io ? phrd_pkg::PHRD_DEST_IO
		: phrd_pkg::PHRD_DEST_DRAM)
		: fixed_hit ? (fixed_to_io ? phrd_pkg::PHRD_DEST_IO
		: phrd_pkg::PHRD_DEST_DRAM)
		: phrd_pkg::PHRD_DEST_NORMAL;
	assign mtype = var_hit ? var_mtype : fixed_hit ? fixed_mtype
		: `PHRD_MTYPE_NONE;

endmodule : phrd_range_match

// file: hdl/phrd_spec_cycle.sv
// entry and exit acknowledge special cycle generator
`timescale 1ns/10ps
module phrd_spec_cycle (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_mode,
	input wire logic entry_cycle_disable,
	input wire logic exit_cycle_disable,
	output logic cyc_valid,
	output phrd_pkg::phrd_cyc_e cyc_kind
);

	logic mode_q;
	wire logic entering;
	wire logic leaving;
	wire logic next_cyc_valid;
	wire phrd_pkg::phrd_cyc_e next_cyc_kind;

	assign entering = in_mode && !mode_q;
	assign leaving = !in_mode && mode_q;
	assign next_cyc_valid = (entering && !entry_cycle_disable) ||
		(leaving && !exit_cycle_disable);
	assign next_cyc_kind = entering ? phrd_pkg::PHRD_CYC_ENTRY
		: phrd_pkg::PHRD_CYC_EXIT;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= 1'b0;
			cyc_valid <= 1'b0;
			cyc_kind <= phrd_pkg::PHRD_CYC_ENTRY;
		end else begin
			mode_q <= in_mode;
			cyc_valid <= next_cyc_valid;
			cyc_kind <= next_cyc_kind;
		end
	end

endmodule : phrd_spec_cycle

// file: verif/phrd_core_model.sv
// behavioural core side: access requests and the mode level
`timescale 1ns/10ps
module phrd_core_model (
	input wire logic pclk,
	output phrd_pkg::phrd_req_s req,
	output logic system_management_mode
);
	initial begin
		req = '0;
		system_management_mode = 1'b0;
	end

	// the address is inverted afterwards so a stale route cannot pass
	task automatic access(input phrd_pkg::phrd_acc_e k, input logic [39:0] a);
		@(posedge pclk);
		req <= '{valid: 1'b1, kind: k, addr: a};
		@(posedge pclk);
		req.valid <= 1'b0;
		req.addr <= ~a;
	endtask : access

	task automatic set_mode(input logic v);
		@(posedge pclk);
		system_management_mode <= v;
	endtask : set_mode
endmodule : phrd_core_model

// file: verif/phrd_top_props.sv
// concurrent checks on the ports of the protected range decoder
`timescale 1ns/10ps
module phrd_top_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input phrd_pkg::phrd_req_s req,
	input wire logic system_management_mode,
	input phrd_pkg::phrd_route_s route,
	input wire logic ack_cycle_valid,
	input phrd_pkg::phrd_cyc_e ack_cycle_kind
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic hit = route.var_hit | route.fixed_hit;

	sequence apb_setup_access;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence mode_entry;
		!system_management_mode ##1 system_management_mode;
	endsequence

	apb_wait_a: assert property (
		apb_setup_access |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	unmapped_err_a: assert property (
		pready |-> pslverr == (paddr[7:5] != 3'h0))
		else $error("slave error does not match the offset");
	route_lat_a: assert property (
		req.valid |=> route.valid && route.addr == $past(req.addr))
		else $error("route missing one cycle after request");
	normal_miss_a: assert property (
		route.valid && !hit |-> route.dest == phrd_pkg::PHRD_DEST_NORMAL
		&& route.mtype == 3'h0) else $error("miss not sent to normal map");
	fixed_span_a: assert property (
		route.valid && route.fixed_hit |-> route.addr[39:17] == 23'h000005)
		else $error("fixed hit outside its span");
	outside_io_a: assert property (
		route.valid && hit && !$past(system_management_mode) |->
		route.dest == phrd_pkg::PHRD_DEST_IO && route.mtype[2:1] == 2'h0)
		else $error("hit outside the mode not sent to io");
	fetch_dram_a: assert property (
		route.valid && hit && $past(system_management_mode) &&
		$past(req.kind) != phrd_pkg::PHRD_ACC_DATA |->
		route.dest == phrd_pkg::PHRD_DEST_DRAM)
		else $error("fetch or walk inside the mode left dram");
	ack_entry_a: assert property (
		ack_cycle_valid && ack_cycle_kind == phrd_pkg::PHRD_CYC_ENTRY |->
		$past(system_management_mode, 2) && !$past(system_management_mode, 3))
		else $error("entry ack without a mode entry");
	ack_exit_a: assert property (
		ack_cycle_valid && ack_cycle_kind == phrd_pkg::PHRD_CYC_EXIT |->
		!$past(system_management_mode, 2) && $past(system_management_mode, 3))
		else $error("exit ack without a mode exit");
	ack_pulse_a: assert property (
		ack_cycle_valid |=> !ack_cycle_valid)
		else $error("ack cycle longer than one clock");
	entry_seen_c: cover property (mode_entry ##2 ack_cycle_valid);
endmodule : phrd_top_props

bind phrd_top phrd_top_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.req(req), .system_management_mode(system_management_mode),
	.route(route), .ack_cycle_valid(ack_cycle_valid),
	.ack_cycle_kind(ack_cycle_kind));

// file: verif/phrd_top_bench.sv
// self-checking bench for the protected range decoder
`timescale 1ns/10ps
`include "phrd_regs.svh"
module phrd_top_bench;
	localparam phrd_pkg::phrd_acc_e KD = phrd_pkg::PHRD_ACC_DATA;
	localparam logic [2:0] NRM = 3'b001;
	localparam logic [2:0] DRM = 3'b010;
	localparam logic [2:0] IO = 3'b100;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic mode;
	logic ack_v;
	phrd_pkg::phrd_req_s req;
	phrd_pkg::phrd_route_s route;
	phrd_pkg::phrd_cyc_e ack_k;
	int mismatches = 0;
	int tests_run = 0;

	always #10 pclk = ~pclk;

	phrd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
		.system_management_mode(mode), .route(route),
		.ack_cycle_valid(ack_v), .ack_cycle_kind(ack_k));
	phrd_core_model u_core (.pclk(pclk), .req(req),
		.system_management_mode(mode));

	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			results();
		end
		if (!w)
			check(prdata, d);
		check({31'h0, pslverr}, {31'h0, a[7:5] != 3'h0});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic acc(input phrd_pkg::phrd_acc_e k, input logic [39:0] a,
			input logic [2:0] dest, input logic [2:0] mt);
		u_core.access(k, a);
		@(posedge pclk);
		check({31'h0, route.valid}, 32'h1);
		check({29'h0, route.dest}, {29'h0, dest});
		check({29'h0, route.mtype}, {29'h0, mt});
	endtask : acc

	// mode change, then a bounded look for the acknowledge pulse
	task automatic ack(input logic v, input logic want, input logic [1:0] k);
		logic seen = 1'b0;
		logic [1:0] kind = 2'h0;
		u_core.set_mode(v);
		repeat (6) begin
			@(posedge pclk);
			if (ack_v === 1'b1) begin
				seen = 1'b1;
				kind = ack_k;
			end
		end
		check({31'h0, seen}, {31'h0, want});
		if (want)
			check({30'h0, kind}, {30'h0, k});
	endtask : ack

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `PHRD_OFS_MASK_LO, 32'h0);
		apb(0, 8'h20, 32'h0);
		apb(1, `PHRD_OFS_HANDLER, 32'h0003_0000);
		apb(0, `PHRD_OFS_HANDLER, 32'h0003_0000);
		// var range 1 MB base, 256 KB long, kept apart from the fixed span
		apb(1, `PHRD_OFS_BASE_LO, 32'h0010_0000);
		apb(1, `PHRD_OFS_MASK_HI, 32'h0000_00ff);
		apb(1, `PHRD_OFS_MASK_LO, 32'hfffc_6521);
		acc(KD, 40'h00_0010_0000, NRM, 3'h0);
		apb(1, `PHRD_OFS_MASK_LO, 32'hfffc_6523);
		acc(KD, 40'h00_0010_0000, IO, 3'h1);
		acc(KD, 40'h00_0013_ffff, IO, 3'h1);
		acc(KD, 40'h00_0014_0000, NRM, 3'h0);
		acc(KD, 40'h00_000f_ffff, NRM, 3'h0);
		acc(KD, 40'h00_000a_0000, IO, 3'h0);
		acc(KD, 40'h00_000b_ffff, IO, 3'h0);
		acc(KD, 40'h00_000c_0000, NRM, 3'h0);
		ack(1'b1, 1'b1, 2'b01);
		acc(KD, 40'h00_0010_0000, DRM, 3'h6);
		acc(KD, 40'h00_000a_0000, DRM, 3'h5);
		ack(1'b0, 1'b1, 2'b10);
		apb(1, `PHRD_OFS_HWCFG, 32'h0000_0006);
		ack(1'b1, 1'b0, 2'b01);
		ack(1'b0, 1'b0, 2'b10);
		apb(0, `PHRD_OFS_CYCCNT, 32'h0000_0101);
		apb(1, `PHRD_OFS_HWCFG, 32'h0000_0007);
		apb(1, `PHRD_OFS_HWCFG, 32'h0);
		apb(0, `PHRD_OFS_HWCFG, 32'h0000_0007);
		apb(1, `PHRD_OFS_BASE_LO, 32'h0);
		apb(0, `PHRD_OFS_BASE_LO, 32'h0010_0000);
		apb(1, `PHRD_OFS_HANDLER, 32'h0);
		apb(0, `PHRD_OFS_HANDLER, 32'h0003_0000);
		u_core.set_mode(1'b1);
		apb(1, `PHRD_OFS_MASK_LO, 32'h0000_000c);
		apb(0, `PHRD_OFS_MASK_LO, 32'hfffc_652f);
		acc(KD, 40'h00_0010_0000, IO, 3'h1);
		acc(KD, 40'h00_000a_0000, IO, 3'h0);
		acc(phrd_pkg::PHRD_ACC_INSTR, 40'h00_0010_0000, DRM, 3'h6);
		acc(phrd_pkg::PHRD_ACC_WALK, 40'h00_000a_0000, DRM, 3'h5);
		// status: last type 5, last dest dram, locked, inside the mode
		apb(0, `PHRD_OFS_STATUS, 32'h0000_0523);
		// the handler reopens both ranges before it leaves the mode
		apb(1, `PHRD_OFS_MASK_LO, 32'h0);
		u_core.set_mode(1'b0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `PHRD_OFS_HWCFG, 32'h0);
		results();
	end
endmodule : phrd_top_bench
